// ### testbench.sv
`timescale 1ns/1ps
`include "uictl_defs.svh"
module testbench;
	import uictl_pkg::*;
	logic sys_clk;
	logic rst;
	uictl_apb_req_t apb_req;
	uictl_apb_rsp_t apb_rsp;
	logic [4:0] tx_fill;
	logic [4:0] rx_fill;
	logic tx_start;
	logic rx_start;
	uictl_events_t events;
	logic tx_active;
	logic rx_active;
	logic fifo_on;
	logic irq;
	logic tx_dma_single_req;
	logic rx_dma_single_req;
	logic rx_dma_burst_req;
	logic [31:0] rdata;
	logic err;
	int bad_count;
	int checks;
	int cycles;
	int act_cnt;
	int m_mask;
	int m_raw;
	int n;
	int thr[5] = '{2, 4, 8, 12, 14};
	logic [11:0] ra[7] = '{`UICTL_CTRL_ADDR, `UICTL_IFLS_ADDR,
		`UICTL_IMSC_ADDR, `UICTL_RIS_ADDR, `UICTL_MIS_ADDR,
		`UICTL_DMACR_ADDR, `UICTL_ICR_ADDR};
	int rv[7] = '{'h300, 'h12, 0, 0, 0, 0, 0};

	uictl_top uictl_top_i (.sys_clk(sys_clk), .rst(rst),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .tx_fill(tx_fill),
		.rx_fill(rx_fill), .tx_start(tx_start), .rx_start(rx_start),
		.events(events), .tx_active(tx_active), .rx_active(rx_active),
		.fifo_on(fifo_on), .irq(irq),
		.tx_dma_single_req(tx_dma_single_req),
		.rx_dma_single_req(rx_dma_single_req),
		.rx_dma_burst_req(rx_dma_burst_req));
	uictl_peer uictl_peer_i (.sys_clk(sys_clk), .tx_fill(tx_fill),
		.rx_fill(rx_fill), .tx_start(tx_start), .rx_start(rx_start),
		.events(events));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (tx_active === 1'b1) act_cnt++;
		if (cycles > 5000) begin
			bad_count++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////
	task test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// master waits on pready, only the cycle ceiling ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		do @(posedge sys_clk); while (apb_rsp.pready !== 1'b1);
		rdata = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input int d);
		apb(1'b1, a, 32'(d));
	endtask : wr
	task rd(input string nm, input logic [11:0] a, input int e);
		apb(1'b0, a, 32'h0);
		chk(nm, rdata, 32'(e));
	endtask : rd
	task cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : cyc
	////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		apb_req = '0;
		void'($urandom(51761));
		cyc(2);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) rd("reset", ra[i], rv[i]);
		apb(1'b0, 12'h024, 32'h0);
		chk("pslverr", err, 1);
		m_mask = $urandom & 'h7ff;
		wr(`UICTL_IMSC_ADDR, m_mask);
		rd("mask", `UICTL_IMSC_ADDR, m_mask);
		for (int i = 0; i < 9; i++) begin
			uictl_peer_i.pulse(uictl_events_t'(9'(1 << i)));
			cyc(4);
			m_raw |= (i > 3) ? 1 << (i + 2) : 1 << i;
			rd("raw", `UICTL_RIS_ADDR, m_raw);
			rd("masked", `UICTL_MIS_ADDR, m_raw & m_mask);
			chk("irq", irq, 32'((m_raw & m_mask) != 0));
		end
		// writes to status views and zero clears change nothing
		wr(`UICTL_RIS_ADDR, 0);
		wr(`UICTL_MIS_ADDR, 0);
		wr(`UICTL_ICR_ADDR, 0);
		rd("raw", `UICTL_RIS_ADDR, m_raw);
		wr(`UICTL_ICR_ADDR, 'h780);
		m_raw &= ~'h780;
		rd("raw", `UICTL_RIS_ADDR, m_raw);
		wr(`UICTL_ICR_ADDR, 'h7ff);
		rd("masked", `UICTL_MIS_ADDR, 0);
		chk("irq", irq, 0);
		for (int c = 0; c < 5; c++) begin
			wr(`UICTL_IFLS_ADDR, c * 9);
			uictl_peer_i.set(thr[c] + 1, thr[c] - 1, 0, 0);
			cyc(3);
			wr(`UICTL_ICR_ADDR, 'h30);
			uictl_peer_i.set(thr[c], thr[c], 0, 0);
			cyc(3);
			rd("level", `UICTL_RIS_ADDR, 'h30);
			wr(`UICTL_ICR_ADDR, 'h30);
			// still beyond the point, but no crossing
			uictl_peer_i.set(thr[c] - 1, thr[c] + 1, 0, 0);
			cyc(3);
			rd("level", `UICTL_RIS_ADDR, 0);
		end
		wr(`UICTL_IFLS_ADDR, 'h12);
		wr(`UICTL_LINE_ADDR, 'h10);
		rd("line", `UICTL_LINE_ADDR, 'h10);
		wr(`UICTL_DMACR_ADDR, 3);
		uictl_peer_i.set(5, 8, 0, 0);
		rd("dma", `UICTL_DMACR_ADDR, 3);
		chk("dma", {fifo_on, tx_dma_single_req, rx_dma_single_req,
			rx_dma_burst_req}, 'hf);
		wr(`UICTL_DMACR_ADDR, 7);
		uictl_peer_i.pulse(uictl_events_t'(9'h100));
		cyc(3);
		chk("dma", {fifo_on, tx_dma_single_req, rx_dma_single_req,
			rx_dma_burst_req}, 'hc);
		wr(`UICTL_ICR_ADDR, 'h400);
		cyc(3);
		chk("dma", {fifo_on, tx_dma_single_req, rx_dma_single_req,
			rx_dma_burst_req}, 'hf);
		wr(`UICTL_LINE_ADDR, 0);
		uictl_peer_i.set(16, 8, 0, 0);
		cyc(3);
		chk("dma", {fifo_on, tx_dma_single_req, rx_dma_single_req,
			rx_dma_burst_req}, 'h2);
		wr(`UICTL_DMACR_ADDR, 0);
		cyc(3);
		chk("dma", {tx_dma_single_req, rx_dma_single_req}, 0);
		// tx and rx on, unit off: nothing may start
		uictl_peer_i.set(0, 0, 1, 1);
		cyc(5);
		chk("active", {tx_active, rx_active}, 0);
		wr(`UICTL_CTRL_ADDR, 'h101);
		n = 0;
		while (tx_active !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		uictl_peer_i.set(0, 0, 0, 1);
		chk("rx active", rx_active, 0);
		wr(`UICTL_CTRL_ADDR, 'h100);
		chk("tx active", tx_active, 1);
		rd("status", `UICTL_STAT_ADDR, 1);
		n = 0;
		while (tx_active === 1'b1 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		chk("char length", act_cnt, `UICTL_CHAR_CYCLES);
		wr(`UICTL_LINE_ADDR, 0);
		wr(`UICTL_CTRL_ADDR, 'h300);
		wr(`UICTL_CTRL_ADDR, 'h301);
		cyc(4);
		chk("rx active", rx_active, 1);
		test_done();
	end
endmodule : testbench

// ### uictl_char.sv
`timescale 1ns/1ps
`include "uictl_defs.svh"

// one character engine slot: runs a character while allowed,
// and once started always finishes it
module uictl_char (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// control
	input wire logic allow,
	input wire logic start,
	// status
	output logic busy,
	output logic done
);
	import uictl_pkg::*;

	typedef struct packed {
		uictl_char_state_t state;
		logic [7:0] count;
		logic done;
	} uictl_char_st_t;

	uictl_char_st_t st_reg;
	uictl_char_st_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		unique case (st_reg.state)
			UICTL_IDLE: begin
				if (allow && start) begin
					st_next.state = UICTL_BUSY;
					st_next.count = `UICTL_CHAR_CYCLES;
				end
			end
			UICTL_BUSY, UICTL_DRAIN: begin
				// finish even if enable dropped [RULE2]
				if (!allow)
					st_next.state = UICTL_DRAIN;
				if (st_reg.count == 8'd1) begin
					st_next.state = UICTL_IDLE;
					st_next.done = 1'b1;
				end
				st_next.count = st_reg.count - 8'd1;
			end
			default: st_next.state = UICTL_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg.state <= UICTL_IDLE;
			st_reg.count <= 8'h00;
			st_reg.done <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy = (st_reg.state != UICTL_IDLE);
	assign done = st_reg.done;

	// the last cycle of a character ends it anyway, so it is left out
	a_char_finish: assert property ( // [RULE2]
		@(posedge sys_clk) disable iff (rst)
		(st_reg.state == UICTL_BUSY && !allow &&
		st_reg.count != 8'd1) |=> busy)
		else $error("character aborted on disable");

endmodule : uictl_char

// ### uictl_defs.svh
`ifndef UICTL_DEFS_SVH
`define UICTL_DEFS_SVH

// register byte addresses
`define UICTL_CTRL_ADDR 12'h000
`define UICTL_LINE_ADDR 12'h004
`define UICTL_IFLS_ADDR 12'h008
`define UICTL_IMSC_ADDR 12'h00C
`define UICTL_RIS_ADDR 12'h010
`define UICTL_MIS_ADDR 12'h014
`define UICTL_ICR_ADDR 12'h018
`define UICTL_DMACR_ADDR 12'h01C
`define UICTL_STAT_ADDR 12'h020

// control and line register fields
`define UICTL_CTRL_UNIT 0
`define UICTL_CTRL_TX 8
`define UICTL_CTRL_RX 9
`define UICTL_CTRL_RESET 16'h0300
`define UICTL_LINE_FIFO 4

// trigger level fields
`define UICTL_RXSEL_LO 3
`define UICTL_TXSEL_LO 0
`define UICTL_IFLS_RESET 16'h0012

// interrupt bit positions
`define UICTL_IRQ_OVERRUN 10
`define UICTL_IRQ_BREAK 9
`define UICTL_IRQ_PARITY 8
`define UICTL_IRQ_FRAMING 7
`define UICTL_IRQ_RXTO 6
`define UICTL_IRQ_TX 5
`define UICTL_IRQ_RX 4
`define UICTL_IRQ_MASK 16'h07FF

// dma control fields
`define UICTL_DMA_RX 0
`define UICTL_DMA_TX 1
`define UICTL_DMA_STOP_ERR 2

// fifo depth and transfer length of one character
`define UICTL_FIFO_DEPTH 5'd16
`define UICTL_CHAR_CYCLES 8'd160

`endif

// ### uictl_peer.sv
`timescale 1ns/1ps
// far side: shift engines and line events, steered by the bench
module uictl_peer (
	// clock
	input wire logic sys_clk,
	// engine side
	output logic [4:0] tx_fill,
	output logic [4:0] rx_fill,
	output logic tx_start,
	output logic rx_start,
	output uictl_pkg::uictl_events_t events
);
	import uictl_pkg::*;
	initial begin
		tx_fill = 5'h0;
		rx_fill = 5'h0;
		tx_start = 1'b0;
		rx_start = 1'b0;
		events = '0;
	end
	task set(input int t, input int r, input logic ts, input logic rs);
		@(posedge sys_clk);
		tx_fill <= 5'(t);
		rx_fill <= 5'(r);
		tx_start <= ts;
		rx_start <= rs;
	endtask : set
	// events last one cycle, never a held level
	task pulse(input uictl_events_t e);
		@(posedge sys_clk);
		events <= e;
		@(posedge sys_clk);
		events <= '0;
	endtask : pulse
endmodule : uictl_peer

// ### uictl_pkg.sv
package uictl_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} uictl_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} uictl_apb_rsp_t;

	// hardware event inputs, one pulse each
	typedef struct packed {
		logic overrun;
		logic brk;
		logic parity;
		logic framing;
		logic rx_timeout;
		logic [3:0] modem;
	} uictl_events_t;

	typedef enum logic [2:0] {
		UICTL_IDLE = 3'b001,
		UICTL_BUSY = 3'b010,
		UICTL_DRAIN = 3'b100
	} uictl_char_state_t;

endpackage : uictl_pkg

// ### uictl_top.sv
// Operation
// RULE1: tx/rx run only with unit enable too
// RULE2: disabling finishes the current character first
// RULE3: software reprograms only after disable and flush
// RULE4: level irqs fire on crossing, not level
// RULE5: trigger selects reset to half full
// RULE6: rx trigger bits 5:3, codes 0..4
// RULE7: tx trigger bits 2:0, codes 0..4
// RULE8: mask register reads back, writes set/clear
// RULE9: common bit positions across irq registers
// RULE10: mask clears to zero on reset
// RULE11: raw status read only, pre-mask
// RULE12: status clears on reset, modem bits aside
// RULE13: masked status is raw and mask
// RULE14: clear register write one clears
// RULE15: dma control read write, resets zero
// RULE16: error irq blocks rx dma requests
// RULE17: tx dma enable requests tx service
// RULE18: no hardware flow control gating
// RULE19: rx dma enable requests rx service
// RULE20: fifo off means one entry deep
// RULE21: combined irq is or of masked
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "uictl_defs.svh"

module uictl_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register bus
	input wire uictl_pkg::uictl_apb_req_t apb_req,
	output uictl_pkg::uictl_apb_rsp_t apb_rsp,
	// fifo fill levels, same clock
	input wire logic [4:0] tx_fill,
	input wire logic [4:0] rx_fill,
	// character start requests from the shift engines
	input wire logic tx_start,
	input wire logic rx_start,
	// error and modem events
	input wire uictl_pkg::uictl_events_t events,
	// control outputs
	output logic tx_active,
	output logic rx_active,
	output logic fifo_on,
	output logic irq,
	output logic tx_dma_single_req,
	output logic rx_dma_single_req,
	output logic rx_dma_burst_req
);
	import uictl_pkg::*;

	// trigger threshold in entries for a select code
	function automatic logic [4:0] lvl(input logic [2:0] sel);
		unique case (sel)
			3'd0: lvl = 5'd2;
			3'd1: lvl = 5'd4;
			3'd2: lvl = 5'd8;
			3'd3: lvl = 5'd12;
			default: lvl = 5'd14;
		endcase
	endfunction : lvl

	function automatic logic is_addr(input logic [11:0] a,
		input logic [11:0] b);
		is_addr = (a == b);
	endfunction : is_addr

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] line;
		logic [15:0] ifls;
		logic [15:0] imsc;
		logic [15:0] ris;
		logic [15:0] dmacr;
		logic [4:0] tx_fill_d;
		logic [4:0] rx_fill_d;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic tx_active;
		logic rx_active;
		logic fifo_on;
		logic irq;
		logic tx_dreq;
		logic rx_sreq;
		logic rx_breq;
	} uictl_st_t;

	uictl_st_t st_reg;
	uictl_st_t st_next;

	logic tx_allow;
	logic rx_allow;
	logic tx_busy;
	logic rx_busy;
	logic tx_done;
	logic rx_done;
	logic [3:0] mdm0_reg;
	logic [3:0] mdm1_reg;

	////////////////////////////////////////////////////////////////
	// character engines

	assign tx_allow = st_reg.ctrl[`UICTL_CTRL_TX] &&
		st_reg.ctrl[`UICTL_CTRL_UNIT]; // [RULE1]
	assign rx_allow = st_reg.ctrl[`UICTL_CTRL_RX] &&
		st_reg.ctrl[`UICTL_CTRL_UNIT]; // [RULE1]

	uictl_char u_tx (
		.sys_clk(sys_clk),
		.rst(rst),
		.allow(tx_allow),
		.start(tx_start),
		.busy(tx_busy),
		.done(tx_done)
	);

	uictl_char u_rx (
		.sys_clk(sys_clk),
		.rst(rst),
		.allow(rx_allow),
		.start(rx_start),
		.busy(rx_busy),
		.done(rx_done)
	);

	// modem events come from pins: synchronise before use
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mdm0_reg <= 4'h0;
			mdm1_reg <= 4'h0;
		end else begin
			// only the second stage feeds the status logic
			mdm0_reg <= events.modem;
			mdm1_reg <= mdm0_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// next state

	logic setup;
	logic access;
	logic wr;
	logic [11:0] a;
	logic [15:0] wd;
	logic [15:0] set_bits;
	logic [15:0] clr_bits;
	logic [15:0] mis;
	logic [4:0] tx_lvl;
	logic [4:0] rx_lvl;
	logic tx_cross;
	logic rx_cross;
	logic rx_err;
	logic hit;

	always_comb begin
		st_next = st_reg;
		setup = apb_req.psel && !apb_req.penable;
		access = apb_req.psel && apb_req.penable && st_reg.pready;
		wr = access && apb_req.pwrite;
		a = apb_req.paddr;
		wd = apb_req.pwdata[15:0];
		tx_lvl = lvl(st_reg.ifls[`UICTL_TXSEL_LO +: 3]); // [RULE7]
		rx_lvl = lvl(st_reg.ifls[`UICTL_RXSEL_LO +: 3]); // [RULE6]
		// edge through the level, not the level itself [RULE4]
		tx_cross = (st_reg.tx_fill_d > tx_lvl) && (tx_fill <= tx_lvl);
		rx_cross = (st_reg.rx_fill_d < rx_lvl) && (rx_fill >= rx_lvl);
		set_bits = 16'h0000;
		set_bits[`UICTL_IRQ_OVERRUN] = events.overrun; // [RULE9]
		set_bits[`UICTL_IRQ_BREAK] = events.brk;
		set_bits[`UICTL_IRQ_PARITY] = events.parity;
		set_bits[`UICTL_IRQ_FRAMING] = events.framing;
		set_bits[`UICTL_IRQ_RXTO] = events.rx_timeout;
		set_bits[`UICTL_IRQ_TX] = tx_cross;
		set_bits[`UICTL_IRQ_RX] = rx_cross;
		set_bits[3:0] = mdm1_reg;
		clr_bits = 16'h0000;
		if (wr && is_addr(a, `UICTL_ICR_ADDR))
			clr_bits = wd & `UICTL_IRQ_MASK; // [RULE14]
		// new event beats a clear in the same cycle
		st_next.ris = ((st_reg.ris & ~clr_bits) | set_bits) &
			`UICTL_IRQ_MASK;
		st_next.tx_fill_d = tx_fill;
		st_next.rx_fill_d = rx_fill;
		st_next.pready = setup;
		st_next.pslverr = 1'b0;
		st_next.prdata = 32'h0000_0000;
		mis = st_next.ris & st_reg.imsc; // [RULE13]
		hit = 1'b1;
		if (setup) begin
			// answer computed in setup, returned in access
			unique case (a)
				`UICTL_CTRL_ADDR: st_next.prdata[15:0] = st_reg.ctrl;
				`UICTL_LINE_ADDR: st_next.prdata[15:0] = st_reg.line;
				`UICTL_IFLS_ADDR: st_next.prdata[15:0] = st_reg.ifls;
				`UICTL_IMSC_ADDR: st_next.prdata[15:0] = st_reg.imsc; // [RULE8]
				`UICTL_RIS_ADDR: st_next.prdata[15:0] = st_reg.ris; // [RULE11]
				`UICTL_MIS_ADDR: st_next.prdata[15:0] =
					st_reg.ris & st_reg.imsc; // [RULE13]
				`UICTL_ICR_ADDR: st_next.prdata = 32'h0000_0000;
				`UICTL_DMACR_ADDR: st_next.prdata[15:0] = st_reg.dmacr;
				`UICTL_STAT_ADDR: st_next.prdata[1:0] = {rx_busy, tx_busy};
				default: hit = 1'b0;
			endcase
			st_next.pslverr = !hit;
		end
		if (wr) begin
			// status views ignore writes [RULE11] [RULE13]
			if (is_addr(a, `UICTL_CTRL_ADDR))
				st_next.ctrl = wd & 16'h0301;
			if (is_addr(a, `UICTL_LINE_ADDR))
				st_next.line = wd & 16'h00FF;
			if (is_addr(a, `UICTL_IFLS_ADDR))
				st_next.ifls = wd & 16'h003F;
			if (is_addr(a, `UICTL_IMSC_ADDR))
				st_next.imsc = wd & `UICTL_IRQ_MASK; // [RULE8]
			if (is_addr(a, `UICTL_DMACR_ADDR))
				st_next.dmacr = wd & 16'h0007; // [RULE15]
		end
		// no flow-control gating exists on tx [RULE18]
		st_next.tx_active = tx_busy;
		st_next.rx_active = rx_busy;
		st_next.fifo_on = st_reg.line[`UICTL_LINE_FIFO]; // [RULE20]
		st_next.irq = |mis; // [RULE21]
		rx_err = |st_next.ris[`UICTL_IRQ_OVERRUN:`UICTL_IRQ_FRAMING];
		st_next.tx_dreq = st_reg.dmacr[`UICTL_DMA_TX] &&
			(tx_fill < `UICTL_FIFO_DEPTH); // [RULE17]
		st_next.rx_sreq = st_reg.dmacr[`UICTL_DMA_RX] &&
			(rx_fill != 5'd0) &&
			!(st_reg.dmacr[`UICTL_DMA_STOP_ERR] && rx_err); // [RULE19] [RULE16]
		// burst only meaningful with buffering active
		st_next.rx_breq = st_reg.dmacr[`UICTL_DMA_RX] &&
			st_reg.line[`UICTL_LINE_FIFO] && (rx_fill >= rx_lvl) &&
			!(st_reg.dmacr[`UICTL_DMA_STOP_ERR] && rx_err); // [RULE16]
	end

	////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.ctrl <= `UICTL_CTRL_RESET;
			st_reg.ifls <= `UICTL_IFLS_RESET; // [RULE5]
			st_reg.imsc <= 16'h0000; // [RULE10]
			st_reg.ris <= 16'h0000; // [RULE12]
			st_reg.dmacr <= 16'h0000; // [RULE15]
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign apb_rsp.prdata = st_reg.prdata;
	assign apb_rsp.pready = st_reg.pready;
	assign apb_rsp.pslverr = st_reg.pslverr;
	assign tx_active = st_reg.tx_active;
	assign rx_active = st_reg.rx_active;
	assign fifo_on = st_reg.fifo_on;
	assign irq = st_reg.irq;
	assign tx_dma_single_req = st_reg.tx_dreq;
	assign rx_dma_single_req = st_reg.rx_sreq;
	assign rx_dma_burst_req = st_reg.rx_breq;

	////////////////////////////////////////////////////////////////
	// checks

	a_tx_gate: assert property ( // [RULE1]
		@(posedge sys_clk) disable iff (rst)
		(!tx_busy && !tx_allow) |=> !tx_busy)
		else $error("tx started while disabled");

	a_rx_gate: assert property ( // [RULE1]
		@(posedge sys_clk) disable iff (rst)
		(!rx_busy && !rx_allow) |=> !rx_busy)
		else $error("rx started while disabled");

	a_cross_set: assert property ( // [RULE4]
		@(posedge sys_clk) disable iff (rst)
		tx_cross |=> st_reg.ris[`UICTL_IRQ_TX])
		else $error("tx level crossing not flagged");

	a_rx_cross: assert property ( // [RULE4]
		@(posedge sys_clk) disable iff (rst)
		rx_cross |=> st_reg.ris[`UICTL_IRQ_RX])
		else $error("rx level crossing not flagged");

	a_no_level: assert property ( // [RULE4]
		@(posedge sys_clk) disable iff (rst)
		($stable(tx_fill) && !st_reg.ris[`UICTL_IRQ_TX] &&
		st_reg.tx_fill_d == tx_fill) |=> !st_reg.ris[`UICTL_IRQ_TX])
		else $error("tx level irq without crossing");

	a_mask_rd: assert property ( // [RULE8]
		@(posedge sys_clk) disable iff (rst)
		(setup && apb_req.paddr == `UICTL_IMSC_ADDR) |=>
		apb_rsp.prdata[15:0] == $past(st_reg.imsc))
		else $error("mask readback wrong");

	a_clr_one: assert property ( // [RULE14]
		@(posedge sys_clk) disable iff (rst)
		(wr && a == `UICTL_ICR_ADDR && wd[`UICTL_IRQ_PARITY] &&
		!events.parity) |=> !st_reg.ris[`UICTL_IRQ_PARITY])
		else $error("clear did not clear");

	a_clr_keep: assert property ( // [RULE14]
		@(posedge sys_clk) disable iff (rst)
		(wr && a == `UICTL_ICR_ADDR && !wd[`UICTL_IRQ_OVERRUN] &&
		st_reg.ris[`UICTL_IRQ_OVERRUN]) |=>
		st_reg.ris[`UICTL_IRQ_OVERRUN])
		else $error("zero write cleared a flag");

	a_set_wins: assert property ( // [RULE9]
		@(posedge sys_clk) disable iff (rst)
		events.overrun |=> st_reg.ris[`UICTL_IRQ_OVERRUN])
		else $error("overrun event lost");

	a_modem_pos: assert property ( // [RULE9]
		@(posedge sys_clk) disable iff (rst)
		mdm1_reg[0] |=> st_reg.ris[0])
		else $error("modem event in wrong bit");

	a_ris_ro: assert property ( // [RULE11]
		@(posedge sys_clk) disable iff (rst)
		(wr && a == `UICTL_RIS_ADDR && set_bits == 16'h0000) |=>
		st_reg.ris == $past(st_reg.ris))
		else $error("raw status changed by write");

	a_mis_rd: assert property ( // [RULE13]
		@(posedge sys_clk) disable iff (rst)
		(setup && apb_req.paddr == `UICTL_MIS_ADDR) |=>
		apb_rsp.prdata[15:0] == ($past(st_reg.ris) & $past(st_reg.imsc)))
		else $error("masked status readback wrong");

	a_irq_or: assert property ( // [RULE21]
		@(posedge sys_clk) disable iff (rst)
		##1 irq == |($past(st_next.ris) & $past(st_reg.imsc)))
		else $error("irq not or of masked");

	a_dma_err: assert property ( // [RULE16]
		@(posedge sys_clk) disable iff (rst)
		(st_reg.dmacr[`UICTL_DMA_STOP_ERR] && rx_err) |=>
		!rx_dma_single_req && !rx_dma_burst_req)
		else $error("rx dma during error");

	a_tx_dma: assert property ( // [RULE17]
		@(posedge sys_clk) disable iff (rst)
		!st_reg.dmacr[`UICTL_DMA_TX] |=> !tx_dma_single_req)
		else $error("tx dma while off");

	a_rx_dma: assert property ( // [RULE19]
		@(posedge sys_clk) disable iff (rst)
		!st_reg.dmacr[`UICTL_DMA_RX] |=>
		!rx_dma_single_req && !rx_dma_burst_req)
		else $error("rx dma while off");

	a_fifo_copy: assert property ( // [RULE20]
		@(posedge sys_clk) disable iff (rst)
		1'b1 |=> fifo_on == $past(st_reg.line[`UICTL_LINE_FIFO]))
		else $error("fifo enable output stale");

endmodule : uictl_top
